/* File: common/cmh_defs.vh */
// register map, field positions and limits of the message handler
// assumes an 8-bit register port with byte addresses
`ifndef CMH_DEFS_VH
`define CMH_DEFS_VH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define CMH_A_RFLG    8'h00
`define CMH_A_RIER    8'h01
`define CMH_A_TFLG    8'h02
`define CMH_A_TCR     8'h03
`define CMH_A_IDAC    8'h04
`define CMH_A_PAT0    8'h08
`define CMH_A_MSK0    8'h0C
`define CMH_RX_PAGE   4'h1
`define CMH_TX_PAGE   2'h1
`define CMH_MSG_LAST  4'hC
`define CMH_RANK_BYTE 4'hD

// ----------------------------------------------------------------------
// receive flag register bits (enable register uses the same layout)
// ----------------------------------------------------------------------
`define CMH_B_WAKE    7
`define CMH_B_RWARN   6
`define CMH_B_TWARN   5
`define CMH_B_RPASS   4
`define CMH_B_TPASS   3
`define CMH_B_BOFF    2
`define CMH_B_OVR     1
`define CMH_B_RXF     0

// ----------------------------------------------------------------------
// transmit flag / control fields, filter control fields
// ----------------------------------------------------------------------
`define CMH_TXE_LSB   0
`define CMH_ABT_LSB   4
`define CMH_MODE_LSB  4
`define CMH_FM_SINGLE 2'h0
`define CMH_FM_DUAL   2'h1
`define CMH_FM_QUAD   2'h2
`define CMH_FM_CLOSED 2'h3

// ----------------------------------------------------------------------
// error counter limits and reset values
// ----------------------------------------------------------------------
`define CMH_REC_WARN  8'h60
`define CMH_REC_PASS  8'h7F
`define CMH_TEC_WARN  9'h060
`define CMH_TEC_PASS  9'h07F
`define CMH_TEC_BOFF  9'h0FF
`define CMH_TXE_RST   3'h7
`define CMH_ZERO8     8'h00

`endif

/* File: design/cmh_core.v */
// message handling core: transmit buffers, acceptance filter, flags
// assumes a protocol engine on clk supplying arbitration, frame
// results, received bytes and error counters; rx pin is asynchronous
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "cmh_defs.vh"

module cmh_core (
  input  wire       clk,
  input  wire       rstn,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       cpu_irq_mask,
  output wire       irq_wakeup,
  output wire       irq_error,
  output wire       irq_receive,
  output wire       irq_transmit,
  output wire       tx_pending,
  input  wire       eng_arb,
  input  wire       eng_done,
  input  wire       eng_fail,
  output reg        tx_grant,
  output reg  [1:0] tx_sel,
  input  wire [3:0] eng_tx_idx,
  output reg  [7:0] tx_byte,
  input  wire       eng_rx_wr,
  input  wire [3:0] eng_rx_idx,
  input  wire [7:0] eng_rx_data,
  input  wire       eng_rx_ok,
  input  wire       eng_rx_own,
  input  wire [7:0] rec_count,
  input  wire [8:0] tec_count,
  input  wire       sleep_mode,
  input  wire       can_rx_pin,
  input  wire       eng_dominant,
  output reg        bus_transmit_pin
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  reg  [7:0] txm [0:47];  // {buffer, byte}; byte 13 is the rank
  reg  [7:0] rxf_buf [0:12];
  reg  [7:0] rxb_buf [0:12];
  reg  [7:0] pat [0:3];
  reg  [7:0] msk [0:3];
  reg  [7:0] rflg;
  reg  [7:0] rier;
  reg  [2:0] tx_buffer_empty_flag;
  reg  [2:0] abort_acknowledge_flag;
  reg  [2:0] abort_request_bit;
  reg  [2:0] txeie;
  reg  [1:0] fmode;
  reg  [1:0] hit;
  reg  [1:0] bg_hit;
  reg        bg_full;
  reg        active;
  reg        rx_s1;
  reg        rx_s2;
  reg        rx_s3;
  integer    k;
  integer    k_sel;
  integer    k_flt;
  integer    k_ctl;

  // one 8-bit maskable comparison; set mask bit means don't care
  function match8;
    input [7:0] id;
    input [7:0] p;
    input [7:0] m;
    begin
      match8 = &(~(id ^ p) | m);
    end
  endfunction

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  wire       wr_rflg = reg_wr & (reg_addr == `CMH_A_RFLG);
  wire       wr_tflg = reg_wr & (reg_addr == `CMH_A_TFLG);
  wire       wr_tcr  = reg_wr & (reg_addr == `CMH_A_TCR);
  wire       tx_area = (reg_addr[7:6] == `CMH_TX_PAGE) &
                       (reg_addr[5:4] != 2'h3) &
                       (reg_addr[3:0] <= `CMH_RANK_BYTE);
  wire       rx_area = (reg_addr[7:4] == `CMH_RX_PAGE) &
                       (reg_addr[3:0] <= `CMH_MSG_LAST);

  // ----------------------------------------------------------------------
  // buffer selection
  // ----------------------------------------------------------------------
  wire [2:0] pend = ~tx_buffer_empty_flag & ~abort_request_bit;
  reg  [1:0] best;
  reg        found;
  reg  [7:0] best_rank;

  // lowest rank wins, equal ranks go to the lower buffer
  always @* begin
    best      = 2'h0;
    found     = 1'b0;
    best_rank = 8'hFF;
    for (k_sel = 0; k_sel < 3; k_sel = k_sel + 1) begin
      if (pend[k_sel] && (!found || txm[k_sel*16+13] < best_rank)) begin
        best      = k_sel[1:0];
        best_rank = txm[k_sel*16+13];
        found     = 1'b1;
      end
    end
  end

  assign tx_pending = found & ~active;

  // grant latched at an arbitration when idle, a buffer is ready and not in sleep; a failed frame goes back to the
  // pool so the next arbitration picks again
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active   <= 1'b0;
      tx_sel   <= 2'h0;
      tx_grant <= 1'b0;
    end else begin
      tx_grant <= 1'b0;
      if (active && (eng_done || eng_fail)) begin
        active <= 1'b0;
      end else if (!active && eng_arb && found && !sleep_mode) begin
        active   <= 1'b1;
        tx_sel   <= best;
        tx_grant <= 1'b1;
      end
    end
  end

  // engine reads the granted buffer a byte at a time
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_byte <= `CMH_ZERO8;
    end else begin
      tx_byte <= txm[{tx_sel, eng_tx_idx}];
    end
  end

  // ----------------------------------------------------------------------
  // per-buffer empty, abort request and abort acknowledge
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : tx_ctl
      wire on_bus = active & (tx_sel == g);
      wire sent   = on_bus & eng_done;
      // abort waits while the frame is on the bus or in sleep
      wire abort  = abort_request_bit[g] & ~tx_buffer_empty_flag[g] & ~on_bus & ~sleep_mode;
      wire sw_go  = wr_tflg & reg_wdata[`CMH_TXE_LSB+g];
      wire sw_abt = wr_tcr & reg_wdata[`CMH_ABT_LSB+g];
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          tx_buffer_empty_flag[g]   <= 1'b1;
          abort_acknowledge_flag[g] <= 1'b0;
          abort_request_bit[g] <= 1'b0;
        end else begin
          // set wins over the clear in the same cycle
          if (sent || abort) begin
            tx_buffer_empty_flag[g] <= 1'b1;
          end else if (sw_go) begin
            tx_buffer_empty_flag[g] <= 1'b0;
          end
          if (abort) begin
            abort_acknowledge_flag[g] <= 1'b1;
          end else if (sent || sw_go) begin
            abort_acknowledge_flag[g] <= 1'b0;
          end
          if (sent || abort || tx_buffer_empty_flag[g]) begin
            abort_request_bit[g] <= 1'b0;
          end else if (sw_abt) begin
            abort_request_bit[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // acceptance filter on the background id bytes
  // ----------------------------------------------------------------------
  reg [3:0] hits;
  reg [1:0] hit_idx;

  always @* begin
    hits = 4'h0;
    k_flt = 0;
    case (fmode)
      `CMH_FM_SINGLE: begin
        hits[0] = match8(rxb_buf[0], pat[0], msk[0]) &
                  match8(rxb_buf[1], pat[1], msk[1]) &
                  match8(rxb_buf[2], pat[2], msk[2]) &
                  match8(rxb_buf[3], pat[3], msk[3]);
      end
      `CMH_FM_DUAL: begin
        hits[0] = match8(rxb_buf[0], pat[0], msk[0]) &
                  match8(rxb_buf[1], pat[1], msk[1]);
        hits[1] = match8(rxb_buf[0], pat[2], msk[2]) &
                  match8(rxb_buf[1], pat[3], msk[3]);
      end
      `CMH_FM_QUAD: begin
        for (k_flt = 0; k_flt < 4; k_flt = k_flt + 1) begin
          hits[k_flt] = match8(rxb_buf[0], pat[k_flt], msk[k_flt]);
        end
      end
      default: hits = 4'h0;
    endcase
    // lowest-numbered filter reported
    if (hits[0]) hit_idx = 2'h0;
    else if (hits[1]) hit_idx = 2'h1;
    else if (hits[2]) hit_idx = 2'h2;
    else hit_idx = 2'h3;
  end

  // own frames outside loop-back never reach the foreground
  wire accept = eng_rx_ok & ~eng_rx_own & (|hits);
  wire copy   = bg_full & ~rflg[`CMH_B_RXF] & ~sleep_mode;

  // ----------------------------------------------------------------------
  // receive buffers: background filled by engine, copied once the foreground is free
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bg_full <= 1'b0;
      bg_hit  <= 2'h0;
      hit     <= 2'h0;
      for (k = 0; k < 13; k = k + 1) begin
        rxb_buf[k] <= `CMH_ZERO8;
        rxf_buf[k] <= `CMH_ZERO8;
      end
    end else begin
      // a held background frame is not overwritten
      if (eng_rx_wr && !bg_full && eng_rx_idx <= `CMH_MSG_LAST) begin
        rxb_buf[eng_rx_idx] <= eng_rx_data;
      end
      if (copy) begin
        for (k = 0; k < 13; k = k + 1) begin
          rxf_buf[k] <= rxb_buf[k];
        end
        hit     <= bg_hit;
        bg_full <= 1'b0;
      end else if (accept && !bg_full) begin
        bg_full <= 1'b1;
        bg_hit  <= hit_idx;
      end
    end
  end

  // ----------------------------------------------------------------------
  // receive line sync and wakeup activity
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
    end else begin
      rx_s1 <= can_rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  // a falling edge means a dominant bit started on the bus
  wire rx_activity = rx_s3 & ~rx_s2;

  // ----------------------------------------------------------------------
  // receive and error flags
  // ----------------------------------------------------------------------
  wire [7:0] cond;
  assign cond[`CMH_B_WAKE]  = sleep_mode & rx_activity;
  assign cond[`CMH_B_RWARN] = rec_count >= `CMH_REC_WARN;
  assign cond[`CMH_B_TWARN] = tec_count >= `CMH_TEC_WARN;
  assign cond[`CMH_B_RPASS] = rec_count > `CMH_REC_PASS;
  assign cond[`CMH_B_TPASS] = tec_count > `CMH_TEC_PASS;
  assign cond[`CMH_B_BOFF]  = tec_count > `CMH_TEC_BOFF;
  assign cond[`CMH_B_OVR]   = accept & bg_full & ~copy;
  assign cond[`CMH_B_RXF]   = copy;

  wire [7:0] w1c = wr_rflg ? reg_wdata : `CMH_ZERO8;

  // a standing cause keeps its flag set against a write of 1
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rflg <= `CMH_ZERO8;
    end else begin
      rflg <= cond | (rflg & ~w1c);
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rier  <= `CMH_ZERO8;
      txeie <= 3'h0;
      fmode <= `CMH_FM_SINGLE;
      for (k_ctl = 0; k_ctl < 4; k_ctl = k_ctl + 1) begin
        pat[k_ctl] <= `CMH_ZERO8;
        msk[k_ctl] <= `CMH_ZERO8;
      end
      for (k_ctl = 0; k_ctl < 48; k_ctl = k_ctl + 1) begin
        txm[k_ctl] <= `CMH_ZERO8;
      end
    end else if (reg_wr) begin
      if (reg_addr == `CMH_A_RIER) rier <= reg_wdata;
      if (reg_addr == `CMH_A_TCR) txeie <= reg_wdata[2:0];
      if (reg_addr == `CMH_A_IDAC) fmode <= reg_wdata[5:4];
      if (reg_addr[7:2] == `CMH_A_PAT0 >> 2) begin
        pat[reg_addr[1:0]] <= reg_wdata;
      end
      if (reg_addr[7:2] == `CMH_A_MSK0 >> 2) begin
        msk[reg_addr[1:0]] <= reg_wdata;
      end
      if (tx_area) txm[reg_addr[5:0]] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // read port: data stands in the cycle after the strobe
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `CMH_ZERO8;
    end else if (reg_rd) begin
      if (tx_area) reg_rdata <= txm[reg_addr[5:0]];
      else if (rx_area) reg_rdata <= rxf_buf[reg_addr[3:0]];
      else if (reg_addr[7:2] == `CMH_A_PAT0 >> 2)
        reg_rdata <= pat[reg_addr[1:0]];
      else if (reg_addr[7:2] == `CMH_A_MSK0 >> 2)
        reg_rdata <= msk[reg_addr[1:0]];
      else begin
        case (reg_addr)
          `CMH_A_RFLG: reg_rdata <= rflg;
          `CMH_A_RIER: reg_rdata <= rier;
          `CMH_A_TFLG: reg_rdata <= {1'b0, abort_acknowledge_flag, 1'b0, tx_buffer_empty_flag};
          `CMH_A_TCR:  reg_rdata <= {1'b0, abort_request_bit, 1'b0, txeie};
          `CMH_A_IDAC: reg_rdata <= {2'h0, fmode, 2'h0, hit};
          default:     reg_rdata <= `CMH_ZERO8;
        endcase
      end
    end else begin
      reg_rdata <= `CMH_ZERO8;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt lines: level while any enabled flag stands and cpu_irq_mask is low
  // ----------------------------------------------------------------------
  wire [7:0] ren = rflg & rier;
  assign irq_wakeup   = ~cpu_irq_mask & ren[`CMH_B_WAKE];
  assign irq_error    = ~cpu_irq_mask & (|ren[6:1]);
  assign irq_receive  = ~cpu_irq_mask & ren[`CMH_B_RXF];
  assign irq_transmit = ~cpu_irq_mask & (|(tx_buffer_empty_flag & txeie));

  // ----------------------------------------------------------------------
  // transmit pin, held recessive during sleep
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_transmit_pin <= 1'b1;
    end else begin
      bus_transmit_pin <= sleep_mode | ~eng_dominant;
    end
  end

endmodule

/* File: testbench/cmh_core_asserts.sv */
// port-level checks of the message handler core
// assumes one clock and the asynchronous active-low reset
`timescale 1ns/1ps

module cmh_core_asserts (
  input logic       clk,
  input logic       rstn,
  input logic [7:0] reg_addr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       cpu_irq_mask,
  input logic       irq_wakeup,
  input logic       irq_error,
  input logic       irq_receive,
  input logic       irq_transmit,
  input logic       tx_pending,
  input logic       eng_arb,
  input logic       tx_grant,
  input logic [7:0] rec_count,
  input logic [8:0] tec_count,
  input logic       sleep_mode,
  input logic       eng_dominant,
  input logic       bus_transmit_pin
);
  // --------
  // properties
  // --------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // flag register read; data shows one cycle later
  logic rdf;
  assign rdf = reg_rd && reg_addr == 8'h00;

  a_grant_arb: assert property (
    eng_arb && tx_pending && !sleep_mode |=> tx_grant)
    else $error("ready buffer not granted");
  a_grant_cause: assert property (
    tx_grant |-> $past(eng_arb) && $past(tx_pending))
    else $error("grant without arbitration");
  a_pin_level: assert property (
    !sleep_mode |=> bus_transmit_pin == !$past(eng_dominant))
    else $error("pin level wrong");
  a_pin_sleep: assert property (
    sleep_mode |=> bus_transmit_pin)
    else $error("pin not recessive in sleep");
  a_irq_mask: assert property (
    cpu_irq_mask |-> !{irq_wakeup, irq_error, irq_receive, irq_transmit})
    else $error("request line high under mask");
  a_warn_flag: assert property (
    rdf && $past(rec_count) >= 8'h60 |=> reg_rdata[6])
    else $error("receive warning missing");
  a_pass_flag: assert property (
    rdf && $past(rec_count) > 8'h7F |=> reg_rdata[4])
    else $error("receive passive missing");
  a_boff_flag: assert property (
    rdf && $past(tec_count) > 9'h0FF |=> reg_rdata[2])
    else $error("bus-off flag missing");
  c_grant: cover property (tx_grant);
  c_rx_irq: cover property ($rose(irq_receive));
  c_tx_irq: cover property ($rose(irq_transmit));
endmodule

bind cmh_core cmh_core_asserts u_cmh_core_asserts (.clk, .rstn, .reg_addr,
  .reg_rd, .reg_rdata, .cpu_irq_mask, .irq_wakeup, .irq_error, .irq_receive,
  .irq_transmit, .tx_pending, .eng_arb, .tx_grant, .rec_count, .tec_count,
  .sleep_mode, .eng_dominant, .bus_transmit_pin);

/* File: testbench/cmh_bus_model.sv */
// stand-in for the protocol engine and the bus behind it
// assumes the core samples these outputs on the rising clock
`timescale 1ns/1ps

module cmh_bus_model (
  input  logic       clk,
  input  logic       tx_grant,
  input  logic [1:0] tx_sel,
  input  logic [7:0] tx_byte,
  output logic       eng_arb,
  output logic       eng_done,
  output logic       eng_fail,
  output logic [3:0] eng_tx_idx,
  output logic       eng_rx_wr,
  output logic [3:0] eng_rx_idx,
  output logic [7:0] eng_rx_data,
  output logic       eng_rx_ok,
  output logic       eng_rx_own,
  output logic       eng_dominant
);
  logic [7:0] got [0:13];
  // idle levels from time zero
  initial begin
    {eng_arb, eng_done, eng_fail, eng_rx_wr, eng_rx_ok} = '0;
    {eng_rx_own, eng_dominant, eng_tx_idx, eng_rx_idx} = '0;
    eng_rx_data = 8'h00;
  end
  // one arbitration; no grant reads back as buffer 3
  task automatic arb(output logic [1:0] sel);
    @(posedge clk);
    eng_arb <= 1'b1;
    @(posedge clk);
    eng_arb <= 1'b0;
    #1 sel = tx_grant ? tx_sel : 2'h3;
  endtask
  // fetch 14 bytes, stall gap cycles, then report sent or lost
  task automatic fin(input logic ok, input int gap);
    for (int n = 0; n < 14; n++) begin
      @(posedge clk);
      eng_tx_idx <= 4'(n);
      eng_dominant <= n[0];
      @(posedge clk);
      #1 got[n] = tx_byte;
    end
    repeat (gap) @(posedge clk);
    eng_done <= ok;
    eng_fail <= !ok;
    eng_dominant <= 1'b0;
    @(posedge clk);
    eng_done <= 1'b0;
    eng_fail <= 1'b0;
  endtask
  // received frame; released data line shows the inverse
  task automatic recv(input logic [31:0] id, input logic own);
    for (int n = 0; n < 13; n++) begin
      @(posedge clk);
      eng_rx_wr <= 1'b1;
      eng_rx_idx <= 4'(n);
      eng_rx_data <= (n < 4) ? id[31-8*n -: 8] : 8'(n);
    end
    @(posedge clk);
    eng_rx_wr <= 1'b0;
    eng_rx_data <= ~eng_rx_data;
    eng_rx_ok <= 1'b1;
    eng_rx_own <= own;
    @(posedge clk);
    eng_rx_ok <= 1'b0;
    eng_rx_own <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* File: testbench/tb_cmh_core.sv */
// self-checking bench of the message handler core
// assumes the core, its checker and the bus model compiled first
`timescale 1ns/1ps

module tb_cmh_core;
  logic clk, rstn, reg_wr, reg_rd, cpu_irq_mask, sleep_mode, can_rx_pin;
  logic irq_wakeup, irq_error, irq_receive, irq_transmit, tx_pending;
  logic tx_grant, bus_transmit_pin, eng_arb, eng_done, eng_fail;
  logic eng_rx_wr, eng_rx_ok, eng_rx_own, eng_dominant;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_byte, rec_count, eng_rx_data;
  logic [8:0] tec_count, t, cv [0:5];
  logic [3:0] eng_tx_idx, eng_rx_idx;
  logic [1:0] tx_sel, sel, s, o, m;
  logic [7:0] pat [0:3], msk [0:3], rank [0:2], msg [0:2][0:12], c;
  logic [2:0] pend, h;
  logic [31:0] id;
  int err_count, num_checks, cyc, r, b, i, k, seed;

  cmh_core u_cmh_core (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cpu_irq_mask, .irq_wakeup, .irq_error, .irq_receive,
    .irq_transmit, .tx_pending, .eng_arb, .eng_done, .eng_fail, .tx_grant,
    .tx_sel, .eng_tx_idx, .tx_byte, .eng_rx_wr, .eng_rx_idx, .eng_rx_data,
    .eng_rx_ok, .eng_rx_own, .rec_count, .tec_count, .sleep_mode,
    .can_rx_pin, .eng_dominant, .bus_transmit_pin);
  cmh_bus_model u_bus (.clk, .tx_grant, .tx_sel, .tx_byte, .eng_arb,
    .eng_done, .eng_fail, .eng_tx_idx, .eng_rx_wr, .eng_rx_idx, .eng_rx_data,
    .eng_rx_ok, .eng_rx_own, .eng_dominant);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("ERROR cycles exp below 20000 got %0d", cyc);
      results();
    end
  end
  // --------
  // bus tasks and expectations
  // --------
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // lowest rank among pending buffers, ties to the lower buffer
  function automatic logic [1:0] best(input logic [2:0] p);
    best = 2'h3;
    for (int j = 2; j >= 0; j--)
      if (p[j] && (best == 2'h3 || rank[j] <= rank[best])) best = 2'(j);
  endfunction
  // accept bit and hit number for a mode and identifier
  function automatic logic [2:0] hitf(input logic [1:0] md,
                                      input logic [31:0] x);
    logic [3:0] q, e;
    logic p;
    for (int j = 0; j < 4; j++) begin
      q[j] = ((x[31:24] ^ pat[j]) & ~msk[j]) == 8'h00;
      e[j] = ((x[31-8*j -: 8] ^ pat[j]) & ~msk[j]) == 8'h00;
    end
    p = ((x[23:16] ^ pat[3]) & ~msk[3]) == 8'h00;
    case (md)
      2'h0: hitf = {&e, 2'h0};
      2'h1: hitf = (e[0] & e[1]) ? 3'h4 : (q[2] & p) ? 3'h5 : 3'h0;
      2'h2: hitf = q[0] ? 3'h4 : q[1] ? 3'h5 :
                   q[2] ? 3'h6 : q[3] ? 3'h7 : 3'h0;
      default: hitf = 3'h0;
    endcase
  endfunction
  function automatic logic [7:0] flg(input logic [7:0] a, input logic [8:0] x);
    flg = {1'b0, a >= 8'h60, x >= 9'h060, a > 8'h7F, x > 9'h07F,
           x > 9'h0FF, 2'h0};
  endfunction
  // --------
  // main sequence
  // --------
  initial begin
    seed = 38635;
    {rstn, reg_wr, reg_rd, cpu_irq_mask, sleep_mode} = '0;
    {reg_addr, reg_wdata, rec_count, tec_count, can_rx_pin} = {33'h0, 1'b1};
    cv = '{9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rchk(8'h02, 8'h07, "txflag");
    rchk(8'h4E, 8'h00, "unmapped");
    for (r = 0; r < 6; r++) begin
      cpu_irq_mask <= r[0];
      for (b = 0; b < 3; b++) begin
        rank[b] = (b == 2) ? ~{8{r[0]}} : 8'($random(seed)) | 8'h01;
        if (b == 1 && r == 2) rank[1] = rank[0];
        for (i = 0; i < 13; i++) begin
          msg[b][i] = 8'($random(seed));
          wr({4'h4 + 4'(b), 4'(i)}, msg[b][i]);
        end
        wr({4'h4 + 4'(b), 4'hD}, rank[b]);
      end
      wr(8'h03, 8'h07);
      pend = 3'b011;
      wr(8'h02, 8'h03);
      u_bus.arb(sel);
      chk("sel", {6'h0, best(pend)}, {6'h0, sel});
      u_bus.fin(1'b0, r % 3);
      pend = 3'b111;
      wr(8'h02, 8'h04);
      chk("irqtx", 8'h00, {7'h0, irq_transmit});
      repeat (3) begin
        s = best(pend);
        u_bus.arb(sel);
        chk("sel", {6'h0, s}, {6'h0, sel});
        u_bus.fin(1'b1, r % 3);
        for (i = 0; i < 14; i++)
          chk("byte", i < 13 ? msg[s][i] : rank[s], u_bus.got[i]);
        pend[s] = 1'b0;
        rchk(8'h02, {5'h0, ~pend}, "txflag");
      end
      chk("irqtx", {7'h0, !cpu_irq_mask}, {7'h0, irq_transmit});
    end
    $display("test priority done");
    wr(8'h03, 8'h00);
    wr(8'h02, 8'h03);
    u_bus.arb(sel);
    s = best(3'b011);
    o = s ^ 2'h1;
    wr(8'h03, 8'h30);
    rchk(8'h02, {1'b0, 3'(1 << o), 1'b0, 3'h4 | 3'(1 << o)}, "abort");
    u_bus.fin(1'b1, 2);
    rchk(8'h02, {1'b0, 3'(1 << o), 1'b0, 3'h7}, "sent");
    rchk(8'h03, 8'h00, "abtreq");
    $display("test abort done");
    cpu_irq_mask <= 1'b0;
    wr(8'h01, 8'h01);
    for (r = 0; r < 32; r++) begin
      m = r[1:0];
      for (k = 0; k < 4; k++) begin
        pat[k] = 8'($random(seed));
        msk[k] = 8'($random(seed) & $random(seed));
        wr(8'h08 + 8'(k), pat[k]);
        wr(8'h0C + 8'(k), msk[k]);
      end
      wr(8'h04, {2'h0, m, 4'h0});
      id = $random(seed);
      if (r[2]) id = {pat[0], pat[1], pat[2], pat[3]}
        ^ (id & {msk[0], msk[1], msk[2], msk[3]});
      if (r[3]) id[31:16] = {pat[2], pat[3]};
      if (r[4]) id[31:24] = pat[{r[3], 1'b1}];
      h = hitf(m, id);
      u_bus.recv(id, 1'b0);
      rchk(8'h00, {7'h0, h[2]}, "rxf");
      chk("irqrx", {7'h0, h[2]}, {7'h0, irq_receive});
      if (h[2]) rchk(8'h04, {2'h0, m, 2'h0, h[1:0]}, "hit");
      if (h[2]) rchk(8'h10, id[31:24], "fgbyte");
      wr(8'h00, 8'h01);
    end
    $display("test filter done");
    for (k = 0; k < 4; k++) wr(8'h0C + 8'(k), 8'hFF);
    wr(8'h04, 8'h00);
    wr(8'h01, 8'h03);
    u_bus.recv(32'h0, 1'b1);
    rchk(8'h00, 8'h00, "own");
    repeat (3) u_bus.recv($random(seed), 1'b0);
    rchk(8'h00, 8'h03, "ovr");
    chk("irqerr", 8'h01, {7'h0, irq_error});
    wr(8'h00, 8'h03);
    rchk(8'h00, 8'h01, "refill");
    wr(8'h00, 8'h01);
    $display("test overrun done");
    wr(8'h01, 8'h7E);
    for (r = 0; r < 12; r++) begin
      t = (r < 6) ? cv[r] : (r == 11) ? 9'h000 : 9'($random(seed));
      c = (r < 6) ? cv[r][7:0] : (r == 11) ? 8'h00 : 8'($random(seed));
      tec_count <= t;
      rec_count <= c;
      wr(8'h00, 8'hFF);
      rchk(8'h00, flg(c, t), "errflag");
      chk("irqerr", {7'h0, |flg(c, t)}, {7'h0, irq_error});
    end
    $display("test error flags done");
    sleep_mode <= 1'b1;
    wr(8'h01, 8'h80);
    can_rx_pin <= 1'b0;
    repeat (5) @(posedge clk);
    rchk(8'h00, 8'h80, "wake");
    chk("irqwake", 8'h01, {7'h0, irq_wakeup});
    can_rx_pin <= 1'b1;
    sleep_mode <= 1'b0;
    wr(8'h00, 8'h80);
    rchk(8'h00, 8'h00, "woken");
    $display("test wakeup done");
    results();
  end
endmodule
